// File: core/analog_input_diag_record.sv
`timescale 1ns/10ps
// =====================================================================
// Diagnostic record of a two channel analog input module.
// =====================================================================

// Contract
// R1: No interrupt; faults only polled.
// R2: Fault lights channel indicator and records.
// R3: Record set 01h full, 00h four bytes.
// R4: Index 2F01h full, 2F00h four bytes.
// R5: Index 5005h, subindex 02h to 13h.
// R6: Class byte 15h: analog, channel info.
// R7: Internal byte: bit3 overflow, bit4 comm.
// R8: Channel kind reads 71h.
// R9: Diagnostic bits per channel read 08h.
// R10: Channel count reads 02h.
// R11: Group byte bits 0,1 per group.
// R12: Channel bits 0,4,6,7 per fault.
// R13: Microsecond counter starts zero, ticks.
// R14: Counter wraps after all ones.
// R15: Timestamp captures counter at event.
// R16: Reserved reads zero; writes ignored.
module analog_input_diag_record
#(
   parameter int CHANNELS = 2,
   parameter int TICK_DIV = diag_pkg::TICK_CYCLES
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Channel fault pins from the analog front end.
   input wire logic [CHANNELS-1:0] ch_param_err_i,
   input wire logic [CHANNELS-1:0] ch_wire_break_i,
   input wire logic [CHANNELS-1:0] ch_underflow_i,
   input wire logic [CHANNELS-1:0] ch_overflow_i,
   // Internal fault levels from logic on this clock.
   input wire logic diag_buf_ovf_i,
   input wire logic comm_err_i,
   // Read request from the backplane side.
   input wire logic rd_req_i,
   input wire diag_pkg::access_path_e path_i,
   input wire logic [7:0] record_set_number_i,
   input wire logic [15:0] object_index_i,
   input wire logic [7:0] object_subindex_i,
   input wire logic [4:0] byte_sel_i,
   // Read answer.
   output logic rsp_valid_o,
   output logic rsp_error_o,
   output logic [7:0] rsp_data_o,
   // Channel fault indicators.
   output logic [CHANNELS-1:0] fault_led_o
);
   import diag_pkg::*;

   // ==================================================================
   // Elaboration checks.
   // ==================================================================

   // The group byte holds two groups, one channel per group.
   initial
   begin
      if (CHANNELS < 1 || CHANNELS > 2)
         $error("analog_input_diag_record: CHANNELS must be 1 or 2.");
      if (TICK_DIV < 1)
         $error("analog_input_diag_record: TICK_DIV must be positive.");
   end

   // ==================================================================
   // Reset release.
   // ==================================================================

   logic rst_meta_b; // First release stage.
   logic rst_sync_b; // Released reset used by the design.

   // Assert at once, release after two clock edges.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ==================================================================
   // Microsecond counter.
   // ==================================================================

   logic [31:0] us_count; // Running microsecond count.

   // R13: the ticker restarts from zero at reset.
   us_ticker
   #(
      .DIVIDE(TICK_DIV)
   )
   u_ticker
   (
      .clk_i(clk_i),
      .rst_b_i(rst_sync_b),
      .count_o(us_count)
   );

   // ==================================================================
   // Channel fault bytes.
   // ==================================================================

   logic [7:0] ch_fault [CHANNELS]; // Live per channel fault bytes.
   logic [CHANNELS-1:0] ch_any; // Channel has any fault.

   // Synchronise each channel's pins and lay out its fault byte.
   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      logic [3:0] pins; // Raw pins of this channel.
      logic [3:0] lvl; // Filtered levels of this channel.
      logic [7:0] fbyte; // Assembled fault byte.

      assign pins = {ch_overflow_i[c], ch_underflow_i[c],
                     ch_wire_break_i[c], ch_param_err_i[c]};

      pin_sync
      #(
         .WIDTH(4)
      )
      u_sync
      (
         .clk_i(clk_i),
         .rst_b_i(rst_sync_b),
         .async_i(pins),
         .level_o(lvl)
      );

      // R12: place each fault at its own bit, reserved bits zero.
      always_comb
      begin
         fbyte = RST_BYTE;
         fbyte[FLT_PARAM_BIT] = lvl[0];
         fbyte[FLT_WIRE_BIT] = lvl[1];
         fbyte[FLT_UNDER_BIT] = lvl[2];
         fbyte[FLT_OVER_BIT] = lvl[3];
      end

      assign ch_fault[c] = fbyte;
      assign ch_any[c] = |fbyte;
   end

   // ==================================================================
   // Module level bytes.
   // ==================================================================

   logic [7:0] internal_fault_flags; // Internal fault byte.
   logic [7:0] channel_group_faults; // Group fault byte.
   logic [7:0] diag_summary; // Summary byte.
   logic [7:0] module_class_info; // Class byte.
   logic [7:0] channel_kind; // Channel type byte.
   logic [7:0] channel_count; // Channel count byte.
   logic [7:0] spare_byte; // Reserved byte.

   // R7: only bits 3 and 4 carry internal faults.
   always_comb
   begin
      internal_fault_flags = RST_BYTE;
      internal_fault_flags[INT_BUF_OVF_BIT] = diag_buf_ovf_i;
      internal_fault_flags[INT_COMM_ERR_BIT] = comm_err_i;
   end

   // R11: one bit per group, reserved bits zero.
   always_comb
   begin
      channel_group_faults = RST_BYTE;
      channel_group_faults[CHANNELS-1:0] = ch_any;
   end

   // Summary flags any fault, internal fault and channel fault.
   always_comb
   begin
      diag_summary = RST_BYTE;
      diag_summary[SUM_INT_BIT] = |internal_fault_flags;
      diag_summary[SUM_CH_BIT] = |ch_any;
      diag_summary[SUM_ANY_BIT] = (|internal_fault_flags) | (|ch_any);
   end

   // R6: analog class code with the channel information flag.
   always_comb
   begin
      module_class_info = RST_BYTE;
      module_class_info[3:0] = CLASS_ANALOG;
      module_class_info[CLASS_CHINFO_BIT] = 1'b1;
   end

   // R8: analog input code in bits 6 to 0, bit 7 reserved.
   assign channel_kind = {1'b0, KIND_ANALOG_IN};

   // R10: count follows the channel parameter.
   assign channel_count = 8'(CHANNELS);

   // R16: reserved byte is constant zero.
   assign spare_byte = RST_BYTE;

   // ==================================================================
   // Event detection and timestamp.
   // ==================================================================

   logic [7:0] prev_int; // Internal byte one cycle ago.
   logic [7:0] prev_ch [CHANNELS]; // Channel bytes one cycle ago.
   logic [CHANNELS-1:0] ch_new; // A channel bit has just been set.
   logic fault_event; // Some fault bit has just been set.
   logic [31:0] fault_timestamp_us; // Count at the last event.

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_edge
      assign ch_new[c] = |(ch_fault[c] & ~prev_ch[c]);
   end

   assign fault_event = (|ch_new) | (|(internal_fault_flags & ~prev_int));

   // Remember the previous fault bytes to spot newly set bits.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         prev_int <= RST_BYTE;
         for (int c = 0; c < CHANNELS; c++) prev_ch[c] <= RST_BYTE;
      end
      else
      begin
         prev_int <= internal_fault_flags;
         for (int c = 0; c < CHANNELS; c++) prev_ch[c] <= ch_fault[c];
      end
   end

   // R15: capture the running count when a fault is recorded.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b) fault_timestamp_us <= RST_TIMESTAMP;
      else if (fault_event) fault_timestamp_us <= us_count;
   end

   // ==================================================================
   // Fault indicators.
   // ==================================================================

   // R2: light the indicator while its channel has a fault.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b) fault_led_o <= '0;
      else fault_led_o <= ch_any;
   end

   // ==================================================================
   // Record image.
   // ==================================================================

   logic [7:0] record [REC_LEN_FULL]; // Byte image of the record.

   assign record[OFS_SUMMARY] = diag_summary;
   assign record[OFS_CLASS] = module_class_info;
   assign record[OFS_SPARE] = spare_byte;
   assign record[OFS_INTERNAL] = internal_fault_flags;
   assign record[OFS_KIND] = channel_kind;
   // R9: fixed count of diagnostic bits.
   assign record[OFS_BITS] = BITS_PER_CH;
   assign record[OFS_COUNT] = channel_count;
   assign record[OFS_GROUP] = channel_group_faults;

   // R16: slots beyond the fitted channels read zero.
   for (genvar s = 0; s < MAX_CH_SLOTS; s++)
   begin : g_slot
      if (s < CHANNELS)
      begin : g_used
         assign record[OFS_CH0 + 5'(s)] = ch_fault[s];
      end
      else
      begin : g_free
         assign record[OFS_CH0 + 5'(s)] = RST_BYTE;
      end
   end

   // Timestamp bytes, least significant byte first.
   for (genvar b = 0; b < 4; b++)
   begin : g_ts
      assign record[OFS_TIMESTAMP + 5'(b)] = fault_timestamp_us[8*b +: 8];
   end

   // ==================================================================
   // Address decoding.
   // ==================================================================

   logic full_len_ok; // Byte lies within the full record.
   logic short_len_ok; // Byte lies within the first four bytes.
   logic rs_hit; // Record set path resolves.
   logic oi_hit; // Object index path resolves.
   logic sub_byte; // Subindex names a one byte field.
   logic sub_ts; // Subindex names the timestamp.
   logic sub_hit; // Subindex path resolves.
   logic [4:0] sub_ofs; // Record offset chosen by subindex.
   logic [4:0] sel_ofs; // Record offset finally chosen.
   logic sel_hit; // Request resolves to a record byte.

   assign full_len_ok = (byte_sel_i < REC_LEN_FULL);
   assign short_len_ok = (byte_sel_i < REC_LEN_SHORT);

   // R3: full record or its first four bytes by record set number.
   assign rs_hit = (record_set_number_i == REC_SET_FULL && full_len_ok)
                || (record_set_number_i == REC_SET_SHORT && short_len_ok);

   // R4: full record or its first four bytes by object index.
   assign oi_hit = (object_index_i == OBJ_IDX_FULL && full_len_ok)
                || (object_index_i == OBJ_IDX_SHORT && short_len_ok);

   // R5: one field per subindex, the timestamp has four bytes.
   assign sub_byte = (object_subindex_i >= SUBIDX_FIRST)
                  && (object_subindex_i <= SUBIDX_LAST_BYTE)
                  && (byte_sel_i == OFS_SUMMARY);
   assign sub_ts = (object_subindex_i == SUBIDX_TIMESTAMP)
                && short_len_ok;
   assign sub_hit = (object_index_i == OBJ_IDX_FIELDS)
                 && (sub_byte || sub_ts);
   assign sub_ofs = sub_ts ? (OFS_TIMESTAMP + byte_sel_i)
                           : 5'(object_subindex_i - SUBIDX_FIRST);

   // Path selection, one decode at a time.
   always_comb
   begin
      if (path_i == PATH_RECORD_SET)
      begin
         sel_hit = rs_hit;
         sel_ofs = byte_sel_i;
      end
      else if (path_i == PATH_OBJECT_INDEX)
      begin
         sel_hit = oi_hit;
         sel_ofs = byte_sel_i;
      end
      else if (path_i == PATH_SUBINDEX)
      begin
         sel_hit = sub_hit;
         sel_ofs = sub_ofs;
      end
      else
      begin
         sel_hit = 1'b0;
         sel_ofs = OFS_SUMMARY;
      end
   end

   // ==================================================================
   // Answer.
   // ==================================================================

   rsp_state_e rsp_state; // Answer state.
   rsp_state_e next_rsp_state; // Next answer state.
   logic [7:0] next_data; // Byte to be answered.

   // R16: unresolved requests answer zero with an error flag.
   assign next_data = sel_hit ? record[sel_ofs] : RST_BYTE;

   // A request is answered on the following cycle.
   always_comb
   begin
      case (rsp_state)
         RSP_IDLE: next_rsp_state = rd_req_i ? RSP_SEND : RSP_IDLE;
         RSP_SEND: next_rsp_state = rd_req_i ? RSP_SEND : RSP_IDLE;
         default: next_rsp_state = RSP_IDLE;
      endcase
   end

   // R1: no interrupt; faults leave the block only by the answer path and the fault indicators.
   always_ff @(posedge clk_i or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         rsp_state <= RSP_IDLE;
         rsp_data_o <= RST_BYTE;
         rsp_error_o <= 1'b0;
      end
      else
      begin
         rsp_state <= next_rsp_state;
         if (rd_req_i)
         begin
            rsp_data_o <= next_data;
            rsp_error_o <= ~sel_hit;
         end
      end
   end

   assign rsp_valid_o = (rsp_state == RSP_SEND);

endmodule // analog_input_diag_record

// File: inc/diag_pkg.sv
// =====================================================================
// Shared constants of the diagnostic record.
// =====================================================================
package diag_pkg;

   // ==================================================================
   // Access path keys.
   // ==================================================================
   localparam logic [7:0] REC_SET_FULL = 8'h01;
   localparam logic [7:0] REC_SET_SHORT = 8'h00;
   localparam logic [15:0] OBJ_IDX_FULL = 16'h2F01;
   localparam logic [15:0] OBJ_IDX_SHORT = 16'h2F00;
   localparam logic [15:0] OBJ_IDX_FIELDS = 16'h5005;
   localparam logic [7:0] SUBIDX_FIRST = 8'h02;
   localparam logic [7:0] SUBIDX_LAST_BYTE = 8'h11;
   localparam logic [7:0] SUBIDX_TIMESTAMP = 8'h13;

   // ==================================================================
   // Byte offsets inside the record.
   // ==================================================================
   localparam logic [4:0] OFS_SUMMARY = 5'h00;
   localparam logic [4:0] OFS_CLASS = 5'h01;
   localparam logic [4:0] OFS_SPARE = 5'h02;
   localparam logic [4:0] OFS_INTERNAL = 5'h03;
   localparam logic [4:0] OFS_KIND = 5'h04;
   localparam logic [4:0] OFS_BITS = 5'h05;
   localparam logic [4:0] OFS_COUNT = 5'h06;
   localparam logic [4:0] OFS_GROUP = 5'h07;
   localparam logic [4:0] OFS_CH0 = 5'h08;
   localparam logic [4:0] OFS_TIMESTAMP = 5'h10;
   localparam logic [4:0] REC_LEN_FULL = 5'h14;
   localparam logic [4:0] REC_LEN_SHORT = 5'h04;
   localparam int MAX_CH_SLOTS = 8;

   // ==================================================================
   // Field positions and reset values.
   // ==================================================================
   localparam logic [3:0] CLASS_ANALOG = 4'h5;
   localparam int CLASS_CHINFO_BIT = 4;
   localparam logic [7:0] RST_CLASS = 8'h15;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] BITS_PER_CH = 8'h08;
   localparam int INT_BUF_OVF_BIT = 3;
   localparam int INT_COMM_ERR_BIT = 4;
   localparam int FLT_PARAM_BIT = 0;
   localparam int FLT_WIRE_BIT = 4;
   localparam int FLT_UNDER_BIT = 6;
   localparam int FLT_OVER_BIT = 7;
   localparam int SUM_ANY_BIT = 0;
   localparam int SUM_INT_BIT = 1;
   localparam int SUM_CH_BIT = 2;
   localparam logic [31:0] RST_TIMESTAMP = 32'h0000_0000;

   // ==================================================================
   // Timing.
   // ==================================================================
   localparam int US_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;

   // Channel type codes in the low seven bits.
   typedef enum logic [6:0] {
      KIND_DIGITAL_IN = 7'h70,
      KIND_ANALOG_IN = 7'h71,
      KIND_DIGITAL_OUT = 7'h72,
      KIND_ANALOG_OUT = 7'h73,
      KIND_ANALOG_INOUT = 7'h74,
      KIND_COUNTER = 7'h76
   } channel_kind_e;

   // Access path selector, Gray coded.
   typedef enum logic [1:0] {
      PATH_RECORD_SET = 2'h0,
      PATH_OBJECT_INDEX = 2'h1,
      PATH_SUBINDEX = 2'h3
   } access_path_e;

   // Answer state machine.
   typedef enum logic [1:0] {
      RSP_IDLE = 2'h0,
      RSP_SEND = 2'h1
   } rsp_state_e;

endpackage

// File: core/pin_sync.sv
`timescale 1ns/10ps
// =====================================================================
// Three-stage synchroniser that accepts a change once stages agree.
// =====================================================================
module pin_sync
#(
   parameter int WIDTH = 4
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Asynchronous level in, filtered level out.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);

   initial
   begin
      if (WIDTH < 1) $error("pin_sync: WIDTH must be at least one.");
   end

   logic [WIDTH-1:0] stage1; // First stage, read only by stage2.
   logic [WIDTH-1:0] stage2; // Second stage.
   logic [WIDTH-1:0] stage3; // Third stage.
   logic [WIDTH-1:0] agree; // Bits where stages two and three match.

   assign agree = ~(stage2 ^ stage3);

   // Shift the chain and take each bit once its late stages agree.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level_o <= '0;
      end
      else
      begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         level_o <= (stage3 & agree) | (level_o & ~agree);
      end
   end

endmodule // pin_sync

// File: core/us_ticker.sv
`timescale 1ns/10ps
// =====================================================================
// Free running microsecond counter.
// =====================================================================
module us_ticker
#(
   parameter int DIVIDE = diag_pkg::TICK_CYCLES
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Current count in microseconds.
   output logic [31:0] count_o
);
   import diag_pkg::*;

   initial
   begin
      if (DIVIDE < 1) $error("us_ticker: DIVIDE must be at least one.");
   end

   localparam int PW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(DIVIDE - 1);

   logic [PW-1:0] prescale; // Cycles within the current microsecond.
   logic tick; // One cycle per microsecond.

   assign tick = (prescale == PRE_LAST);

   // R13: start at zero, step each microsecond.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prescale <= '0;
         count_o <= RST_TIMESTAMP;
      end
      else
      begin
         prescale <= tick ? '0 : prescale + PW'(1);
         // R14: natural wrap past all ones.
         if (tick) count_o <= count_o + 32'h0000_0001;
      end
   end

endmodule // us_ticker

// File: testbench/diag_record_assertions.sv
`timescale 1ns/10ps
// ==========
// Checks on the read answer and the first channel indicator.
module diag_record_checker
import diag_pkg::*;
#(
   parameter int CHANNELS = 2,
   parameter int TICK_DIV = 100
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fault levels.
   input wire logic [CHANNELS-1:0] ch_param_err_i,
   input wire logic [CHANNELS-1:0] ch_wire_break_i,
   input wire logic [CHANNELS-1:0] ch_underflow_i,
   input wire logic [CHANNELS-1:0] ch_overflow_i,
   input wire logic diag_buf_ovf_i,
   input wire logic comm_err_i,
   // Read request.
   input wire logic rd_req_i,
   input wire diag_pkg::access_path_e path_i,
   input wire logic [7:0] record_set_number_i,
   input wire logic [15:0] object_index_i,
   input wire logic [7:0] object_subindex_i,
   input wire logic [4:0] byte_sel_i,
   // Answer and indicators.
   input wire logic rsp_valid_o,
   input wire logic rsp_error_o,
   input wire logic [7:0] rsp_data_o,
   input wire logic [CHANNELS-1:0] fault_led_o
);
   // A one-byte field read through the subindex path.
   wire sub_rd = rd_req_i && path_i == PATH_SUBINDEX && object_index_i == OBJ_IDX_FIELDS
      && byte_sel_i == 5'h00;
   // Any fault present on the first channel.
   wire f0 = ch_param_err_i[0] | ch_wire_break_i[0] | ch_underflow_i[0] | ch_overflow_i[0];
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_valid_next:
   assert property (rd_req_i |=> rsp_valid_o) else $error("answer missing");
   a_valid_cause:
   assert property (rsp_valid_o |-> $past(rd_req_i)) else $error("answer without poll");
   a_error_data:
   assert property (rsp_valid_o && rsp_error_o |-> rsp_data_o == 8'h00) else $error("error data");
   a_class_byte:
   assert property (sub_rd && object_subindex_i == 8'h03 |=> rsp_data_o == RST_CLASS)
      else $error("class byte wrong");
   a_kind_byte:
   assert property (sub_rd && object_subindex_i == 8'h06 |=> rsp_data_o == 8'h71)
      else $error("kind byte wrong");
   a_bits_byte:
   assert property (sub_rd && object_subindex_i == 8'h07 |=> rsp_data_o == 8'h08)
      else $error("bit count wrong");
   a_count_byte:
   assert property (sub_rd && object_subindex_i == 8'h08 |=> rsp_data_o == 8'h02)
      else $error("channel count wrong");
   a_short_limit:
   assert property (rd_req_i && path_i == PATH_RECORD_SET && record_set_number_i == 8'h00
      && byte_sel_i >= 5'h04 |=> rsp_error_o) else $error("short view too long");
   a_led_on:
   assert property (f0 [*8] |=> fault_led_o[0]) else $error("indicator stays off");
   a_led_off:
   assert property (!f0 [*8] |=> !fault_led_o[0]) else $error("indicator stays on");
endmodule // diag_record_checker
bind analog_input_diag_record diag_record_checker #(
   .CHANNELS(CHANNELS),
   .TICK_DIV(TICK_DIV)
) u_diag_record_checker (.clk_i, .rst_b_i, .ch_param_err_i, .ch_wire_break_i,
   .ch_underflow_i, .ch_overflow_i, .diag_buf_ovf_i, .comm_err_i, .rd_req_i, .path_i,
   .record_set_number_i, .object_index_i, .object_subindex_i, .byte_sel_i, .rsp_valid_o,
   .rsp_error_o, .rsp_data_o, .fault_led_o);

// File: testbench/backplane_host.sv
`timescale 1ns/10ps
// ==========
// Backplane host that polls the record one byte at a time.
module backplane_host
import diag_pkg::*;
(
   // Clock.
   input wire logic clk_i,
   // Request.
   output logic rd_req_o,
   output diag_pkg::access_path_e path_o,
   output logic [7:0] rsn_o,
   output logic [15:0] idx_o,
   output logic [7:0] sub_o,
   output logic [4:0] sel_o,
   // Answer.
   input wire logic valid_i,
   input wire logic err_i,
   input wire logic [7:0] data_i
);
   // Idle request at time zero.
   initial
   begin
      rd_req_o = 1'b0;
      path_o = PATH_RECORD_SET;
      {rsn_o, idx_o, sub_o, sel_o} = '0;
   end
   // keyed byte poll; keys scrambled once taken.
   task automatic read(input access_path_e p, input logic [15:0] key, input logic [7:0] sub,
      input logic [4:0] sel, output logic [7:0] d, output logic e, output bit ok);
      ok = 1'b0;
      @(posedge clk_i);
      rd_req_o <= 1'b1;
      path_o <= p;
      rsn_o <= key[7:0];
      idx_o <= key;
      sub_o <= sub;
      sel_o <= sel;
      @(posedge clk_i);
      rd_req_o <= 1'b0;
      {rsn_o, idx_o, sub_o, sel_o} <= ~{key[7:0], key, sub, sel};
      // Bounded wait for the answer.
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(negedge clk_i);
         if (valid_i === 1'b1)
         begin
            d = data_i;
            e = err_i;
            ok = 1'b1;
         end
      end
   endtask
endmodule // backplane_host

// File: testbench/tb_top.sv
`timescale 1ns/10ps
// ==========
// Self-checking bench of the diagnostic record.
module tb_top;
   import diag_pkg::*;
   localparam int DIV = 4;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] pe = 2'h0, wb = 2'h0, uf = 2'h0, ov = 2'h0, led;
   logic bo = 1'b0, ce = 1'b0, req, valid, err, e;
   access_path_e path;
   logic [15:0] idx;
   logic [7:0] rsn, sub, data, d;
   logic [4:0] sel;
   logic [31:0] rng = 32'h0ca0_6f3f, r, ts, first;
   bit ok;
   int err_count = 0, checked = 0, cyc = 0, c;
   analog_input_diag_record #(.CHANNELS(2), .TICK_DIV(DIV)) u_analog_input_diag_record (
      .clk_i(clk), .rst_b_i(rst_b), .ch_param_err_i(pe), .ch_wire_break_i(wb),
      .ch_underflow_i(uf), .ch_overflow_i(ov), .diag_buf_ovf_i(bo), .comm_err_i(ce),
      .rd_req_i(req), .path_i(path), .record_set_number_i(rsn), .object_index_i(idx),
      .object_subindex_i(sub), .byte_sel_i(sel), .rsp_valid_o(valid), .rsp_error_o(err),
      .rsp_data_o(data), .fault_led_o(led));
   backplane_host u_backplane_host (.clk_i(clk), .rd_req_o(req), .path_o(path), .rsn_o(rsn),
      .idx_o(idx), .sub_o(sub), .sel_o(sel), .valid_i(valid), .err_i(err), .data_i(data));
   // Clock and the cycle count since reset release.
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (rst_b)
         cyc <= cyc + 1;
   // Repeatable random source.
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // Expected fault byte of one channel.
   function automatic logic [7:0] chb(int k);
      return {ov[k], uf[k], 1'b0, wb[k], 3'h0, pe[k]};
   endfunction
   // Expected record byte at an offset, from the present fault levels.
   function automatic logic [7:0] exp_byte(int off);
      logic [7:0] i;
      logic [7:0] g;
      i = {3'h0, ce, bo, 3'h0};
      g = {6'h00, |chb(1), |chb(0)};
      case (off)
         0: return {5'h00, |g, |i, |{g, i}};
         1: return RST_CLASS;
         3: return i;
         4: return 8'h71;
         5: return 8'h08;
         6: return 8'h02;
         7: return g;
         8: return chb(0);
         9: return chb(1);
         default: return 8'h00;
      endcase
   endfunction
   // Compares and counts.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run.
   task automatic complete_run();
      $display("Counts: %0d checked, %0d mismatched", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One poll compared with its expected data and error flag.
   task automatic rd(input access_path_e p, input logic [15:0] key, input logic [7:0] s,
      input logic [4:0] bsel, input logic [7:0] ed, input logic ee);
      u_backplane_host.read(p, key, s, bsel, d, e, ok);
      check({ok, e, d}, {1'b1, ee, ed});
      if (!ok)
         complete_run();
   endtask
   // Hang guard.
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      complete_run();
   end
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 20; k++)
         rd(PATH_RECORD_SET, 16'h0001, 8'h00, 5'(k), exp_byte(k), 1'b0);
      rd(PATH_RECORD_SET, 16'h0000, 8'h00, 5'h03, 8'h00, 1'b0);
      rd(PATH_RECORD_SET, 16'h0000, 8'h00, 5'h04, 8'h00, 1'b1);
      rd(access_path_e'(2'h2), 16'h0001, 8'h00, 5'h00, 8'h00, 1'b1);
      rd(PATH_OBJECT_INDEX, 16'h2F00, 8'h00, 5'h01, RST_CLASS, 1'b0);
      rd(PATH_OBJECT_INDEX, 16'h2F00, 8'h00, 5'h04, 8'h00, 1'b1);
      rd(PATH_OBJECT_INDEX, 16'h2F01, 8'h00, 5'h14, 8'h00, 1'b1);
      rd(PATH_SUBINDEX, 16'h5005, 8'h12, 5'h00, 8'h00, 1'b1);
      $display("test keys done");
      for (int k = 0; k < 8; k++)
      begin
         r = (k == 0) ? 32'h0000_0000 : xs();
         @(posedge clk) {ce, bo, ov, uf, wb, pe} <= r[9:0];
         repeat (10) @(posedge clk);
         @(negedge clk);
         check(led, {|chb(1), |chb(0)});
         for (int s = 2; s < 18; s++)
            rd(PATH_SUBINDEX, 16'h5005, 8'(s), 5'h00, exp_byte(s - 2), 1'b0);
         r = xs();
         rd(r[8] ? PATH_OBJECT_INDEX : PATH_RECORD_SET, r[8] ? 16'h2F01 : 16'h0001, 8'h00,
            5'(r[3:0]), exp_byte(r[3:0]), 1'b0);
      end
      $display("test faults done");
      @(posedge clk) {ce, bo, ov, uf, wb, pe} <= 10'h000;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      c = cyc;
      for (int t = 0; t < 2; t++)
      begin
         repeat (40) @(posedge clk);
         for (int b = 0; b < 4; b++)
         begin
            u_backplane_host.read(PATH_SUBINDEX, 16'h5005, 8'h13, 5'(b), d, e, ok);
            check({ok, e}, 2'b10);
            ts[8*b +: 8] = d;
         end
         if (t == 0)
            first = ts;
      end
      check(first >= (c - 6) / DIV && first <= c / DIV + 1, 1'b1);
      check(ts, first);
      $display("test timestamp done");
      complete_run();
   end
endmodule // tb_top
